/* File: verilog/snvwp_core.sv */
/*
  Device-side serial memory front end: command shifter with write-enable
  latch, block protect, status lock with protect pin, and hold pause.
  Assumes the memory array sits outside on core_clk_i and returns read
  data combinationally in the cycle its read strobe is high; all pins
  are asynchronous to core_clk_i and are synchronised here.
  Edges are found by comparing two synchronised samples, so each sck
  high and low phase must last at least three core cycles, and chip
  select must stay high for at least three core cycles between
  commands. The host may toggle sck while hold is low but returns it to
  the level it had when hold fell before hold rises again, and enters
  hold only with sck settled at that level.
*/
`default_nettype none
`include "snvwp_regs.svh"

module snvwp_core (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Serial link pins.
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_si_i,
  input wire logic spi_hold_n_i,
  input wire logic wp_n_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  // Memory array port.
  output snvwp_pkg::snvwp_mem_req_s mem_req_o,
  input wire logic [7:0] mem_rd_data_i,
  // Status view.
  output snvwp_pkg::snvwp_status_s status_o,
  output logic hold_active_o
);

  // The whole state, held as one registered word.
  snvwp_pkg::snvwp_state_s state_reg;
  snvwp_pkg::snvwp_state_s state_next;

  // True when the byte address falls inside the range chosen by the
  // two protect bits.
  function automatic logic addr_protected(
    input logic [`SNVWP_ADDR_W-1:0] addr,
    input logic [1:0] bp
  );
    logic hit;
    hit = 1'b0;
    unique case (bp)
      2'b00: hit = 1'b0;
      2'b01: hit = (addr >= `SNVWP_QUARTER_BASE);
      2'b10: hit = (addr >= `SNVWP_HALF_BASE);
      2'b11: hit = 1'b1;
    endcase
    return hit;
  endfunction : addr_protected

  // Packs the status fields into the byte shifted out on a status read.
  function automatic logic [7:0] status_byte(input snvwp_pkg::snvwp_status_s st);
    logic [7:0] b;
    b = 8'h00;
    b[`SNVWP_ST_LOCK_POS] = st.lock;
    b[`SNVWP_ST_SPARE_HI:`SNVWP_ST_SPARE_LO] = st.spare;
    b[`SNVWP_ST_BP_HI:`SNVWP_ST_BP_LO] = st.bp;
    b[`SNVWP_ST_LATCH_POS] = st.latch;
    return b;
  endfunction : status_byte

  // True on the last bit of a byte, counted from zero.
  function automatic logic byte_done(input logic [4:0] cnt);
    return cnt == `SNVWP_BYTE_BITS;
  endfunction : byte_done

  // Next byte address; the top of the array wraps round to zero.
  function automatic logic [`SNVWP_ADDR_W-1:0] next_addr(
    input logic [`SNVWP_ADDR_W-1:0] addr
  );
    return 17'(addr + 17'h00001);
  endfunction : next_addr

  logic cs_high;
  logic hold_now;
  logic sck_rise;
  logic sck_fall;
  logic reading;
  logic [7:0] in_byte;
  logic [23:0] in_word;

  always_comb begin
    cs_high = state_reg.sync.cs_n[1];
    // A deselected device ignores the hold pin altogether.
    hold_now = !cs_high && !state_reg.sync.hold_n[1];
    // Edges of the synchronised clock against last cycle's sample.
    sck_rise = state_reg.sync.sck[1] && !state_reg.sck_prev;
    sck_fall = !state_reg.sync.sck[1] && state_reg.sck_prev;
    reading = (state_reg.phase == snvwp_pkg::SNVWP_PH_RDATA) ||
              (state_reg.phase == snvwp_pkg::SNVWP_PH_STREAD);
    in_word = {state_reg.shift_in[22:0], state_reg.sync.si[1]};
    in_byte = in_word[7:0];
  end

  always_comb begin
    state_next = state_reg;
    state_next.mem.wr = 1'b0;
    state_next.mem.rd = 1'b0;

    // Two-stage synchronisers: stage 1 feeds only stage 2.
    state_next.sync.cs_n = {state_reg.sync.cs_n[0], spi_cs_n_i};
    state_next.sync.sck = {state_reg.sync.sck[0], spi_sck_i};
    state_next.sync.si = {state_reg.sync.si[0], spi_si_i};
    state_next.sync.hold_n = {state_reg.sync.hold_n[0], spi_hold_n_i};
    state_next.sync.wp_n = {state_reg.sync.wp_n[0], wp_n_i};

    state_next.hold = hold_now;

    // The clock history freezes in hold, so a release at the entry level
    // (the host keeps to this) produces no spurious edge.
    if (!hold_now) begin
      state_next.sck_prev = state_reg.sync.sck[1];
    end

    if (cs_high) begin
      // End of frame, or abort of a held command. Only a recognised write
      // command clears the latch; anything else leaves it as it was.
      if (state_reg.wr_recognised) begin
        state_next.status.latch = 1'b0;
      end
      state_next.phase = snvwp_pkg::SNVWP_PH_OPCODE;
      state_next.bit_cnt = 5'h00;
      state_next.wr_recognised = 1'b0;
      state_next.is_write = 1'b0;
      state_next.load_pend = 1'b0;
      state_next.so_oe = 1'b0;
      state_next.so = 1'b0;
    end else if (hold_now) begin
      // Progress is kept; nothing shifts and the output floats.
      state_next.so_oe = 1'b0;
    end else begin
      if (state_reg.load_pend) begin
        if (state_reg.phase == snvwp_pkg::SNVWP_PH_WDATA) begin
          // The finished write byte has left with its own address; step on.
          state_next.mem.addr = next_addr(state_reg.mem.addr);
        end else begin
          state_next.out_shift = state_reg.load_status ?
                                 status_byte(state_reg.status) : mem_rd_data_i;
        end
        state_next.load_pend = 1'b0;
      end

      if (sck_rise) begin
        state_next.shift_in = in_word;
        state_next.bit_cnt = 5'(state_reg.bit_cnt + 5'h01);
        unique case (state_reg.phase)
          snvwp_pkg::SNVWP_PH_OPCODE: begin
            if (state_reg.bit_cnt == `SNVWP_BYTE_BITS) begin
              state_next.bit_cnt = 5'h00;
              state_next.phase = snvwp_pkg::SNVWP_PH_IDLE;
              // Latch set and clear act at once, not at cs rising.
              unique case (in_byte)
                `SNVWP_OP_LATCH_SET: begin
                  state_next.status.latch = 1'b1;
                end
                `SNVWP_OP_LATCH_CLEAR: begin
                  state_next.status.latch = 1'b0;
                end
                `SNVWP_OP_STATUS_READ: begin
                  state_next.phase = snvwp_pkg::SNVWP_PH_STREAD;
                  state_next.load_pend = 1'b1;
                  state_next.load_status = 1'b1;
                end
                `SNVWP_OP_STATUS_WRITE: begin
                  state_next.phase = snvwp_pkg::SNVWP_PH_STWRITE;
                  state_next.wr_recognised = 1'b1;
                end
                `SNVWP_OP_MEM_READ: begin
                  state_next.phase = snvwp_pkg::SNVWP_PH_ADDR;
                  state_next.is_write = 1'b0;
                end
                `SNVWP_OP_MEM_WRITE: begin
                  state_next.phase = snvwp_pkg::SNVWP_PH_ADDR;
                  state_next.is_write = 1'b1;
                  state_next.wr_recognised = 1'b1;
                end
                default: begin
                  // An unknown opcode parks the frame until cs rises.
                  state_next.phase = snvwp_pkg::SNVWP_PH_IDLE;
                end
              endcase
            end
          end
          snvwp_pkg::SNVWP_PH_ADDR: begin
            if (state_reg.bit_cnt == `SNVWP_ADDR_BITS) begin
              // The upper seven address bits carry no meaning.
              state_next.mem.addr = in_word[`SNVWP_ADDR_W-1:0];
              state_next.bit_cnt = 5'h00;
              if (state_reg.is_write) begin
                state_next.phase = snvwp_pkg::SNVWP_PH_WDATA;
              end else begin
                state_next.phase = snvwp_pkg::SNVWP_PH_RDATA;
                state_next.mem.rd = 1'b1;
                state_next.load_pend = 1'b1;
                state_next.load_status = 1'b0;
              end
            end
          end
          snvwp_pkg::SNVWP_PH_WDATA: begin
            if (byte_done(state_reg.bit_cnt)) begin
              state_next.bit_cnt = 5'h00;
              // A refused byte still advances the address, silently. The
              // step waits one cycle so the strobe leaves with its own address.
              if (state_reg.status.latch &&
                  !addr_protected(state_reg.mem.addr, state_reg.status.bp)) begin
                state_next.mem.wr = 1'b1;
                state_next.mem.wdata = in_byte;
              end
              state_next.load_pend = 1'b1;
            end
          end
          snvwp_pkg::SNVWP_PH_RDATA: begin
            if (byte_done(state_reg.bit_cnt)) begin
              state_next.bit_cnt = 5'h00;
              // Each further byte fetches the next address, wrapping at the top.
              state_next.mem.addr = next_addr(state_reg.mem.addr);
              state_next.mem.rd = 1'b1;
              state_next.load_pend = 1'b1;
              state_next.load_status = 1'b0;
            end
          end
          snvwp_pkg::SNVWP_PH_STREAD: begin
            // The status byte repeats every eight clocks until cs rises.
            if (byte_done(state_reg.bit_cnt)) begin
              state_next.bit_cnt = 5'h00;
              state_next.load_pend = 1'b1;
              state_next.load_status = 1'b1;
            end
          end
          snvwp_pkg::SNVWP_PH_STWRITE: begin
            if (state_reg.bit_cnt == `SNVWP_BYTE_BITS) begin
              state_next.bit_cnt = 5'h00;
              state_next.phase = snvwp_pkg::SNVWP_PH_IDLE;
              // The latch bit and bit 0 of the byte are never stored.
              if (state_reg.status.latch &&
                  (!state_reg.status.lock || state_reg.sync.wp_n[1])) begin
                state_next.status.lock = in_byte[`SNVWP_ST_LOCK_POS];
                state_next.status.spare = in_byte[`SNVWP_ST_SPARE_HI:`SNVWP_ST_SPARE_LO];
                state_next.status.bp = in_byte[`SNVWP_ST_BP_HI:`SNVWP_ST_BP_LO];
              end
            end
          end
          snvwp_pkg::SNVWP_PH_IDLE: begin
            state_next.bit_cnt = 5'h00;
          end
          default: begin
            state_next.phase = snvwp_pkg::SNVWP_PH_IDLE;
          end
        endcase
      end

      // SO moves on the falling edge, so it is settled at the host's next rise.
      if (sck_fall && reading) begin
        state_next.so = state_reg.out_shift[7];
        state_next.out_shift = {state_reg.out_shift[6:0], 1'b0};
      end

      state_next.so_oe = reading;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // Select, hold and protect read inactive; the clock stages match sck_prev.
      state_reg.sync <= 10'h33F;
      state_reg.sck_prev <= 1'b0;
      state_reg.phase <= snvwp_pkg::SNVWP_PH_OPCODE;
      state_reg.bit_cnt <= 5'h00;
      state_reg.shift_in <= 24'h000000;
      state_reg.is_write <= 1'b0;
      state_reg.wr_recognised <= 1'b0;
      state_reg.status.lock <= `SNVWP_RST_LOCK;
      state_reg.status.spare <= `SNVWP_RST_SPARE;
      state_reg.status.bp <= `SNVWP_RST_BP;
      state_reg.status.latch <= 1'b0;
      state_reg.load_pend <= 1'b0;
      state_reg.load_status <= 1'b0;
      state_reg.out_shift <= 8'h00;
      state_reg.so <= 1'b0;
      state_reg.so_oe <= 1'b0;
      state_reg.hold <= 1'b0;
      state_reg.mem <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign spi_so_o = state_reg.so;
  assign spi_so_oe_o = state_reg.so_oe;
  assign mem_req_o = state_reg.mem;
  assign status_o = state_reg.status;
  assign hold_active_o = state_reg.hold;

endmodule : snvwp_core

`default_nettype wire

/* File: verilog/snvwp_regs.svh */
/*
  Constants of the serial memory write-protect and hold block: opcodes,
  status bit positions, protect range bounds and reset values.
  Assumes it is included once per file by its bare name.
*/
// Functional notes
// - Protect bits 00 leave whole array writable.
// - Protect 01 refuses writes 18000h through 1FFFFh.
// - Protect 10 refuses writes 10000h through 1FFFFh.
// - Protect 11 refuses writes to whole array.
// - Clear latch rejects array and status writes.
// - Set latch writes only outside protected range.
// - Status write needs lock clear or pin high.
// - Hold low with select low pauses command.
// - During hold clock and data are ignored.
// - Read output floats while hold lasts.
// - Select rising during hold aborts the command.
// - Unrecognised aborted command keeps latch value.
// - Latch set, cleared, and cleared after writes.
// - Protect and lock bits written, read as status.
`ifndef SNVWP_REGS_SVH
`define SNVWP_REGS_SVH

`define SNVWP_OP_LATCH_SET 8'h06
`define SNVWP_OP_LATCH_CLEAR 8'h04
`define SNVWP_OP_STATUS_READ 8'h05
`define SNVWP_OP_STATUS_WRITE 8'h01
`define SNVWP_OP_MEM_READ 8'h03
`define SNVWP_OP_MEM_WRITE 8'h02

`define SNVWP_ADDR_W 17
`define SNVWP_ADDR_BITS 5'h17
`define SNVWP_BYTE_BITS 5'h07

`define SNVWP_QUARTER_BASE 17'h18000
`define SNVWP_HALF_BASE 17'h10000

`define SNVWP_ST_LOCK_POS 7
`define SNVWP_ST_SPARE_HI 6
`define SNVWP_ST_SPARE_LO 4
`define SNVWP_ST_BP_HI 3
`define SNVWP_ST_BP_LO 2
`define SNVWP_ST_LATCH_POS 1

`define SNVWP_RST_LOCK 1'h0
`define SNVWP_RST_SPARE 3'h0
`define SNVWP_RST_BP 2'h0

`endif

/* File: verilog/snvwp_pkg.sv */
/*
  Types of the serial memory write-protect and hold block.
  Assumes snvwp_regs.svh is on the include path.
*/
`default_nettype none
`include "snvwp_regs.svh"

package snvwp_pkg;

  typedef enum logic [2:0] {
    SNVWP_PH_OPCODE = 3'b000,
    SNVWP_PH_ADDR = 3'b001,
    SNVWP_PH_WDATA = 3'b010,
    SNVWP_PH_RDATA = 3'b011,
    SNVWP_PH_STREAD = 3'b100,
    SNVWP_PH_STWRITE = 3'b101,
    SNVWP_PH_IDLE = 3'b110
  } snvwp_phase_e;

  typedef struct packed {
    logic [1:0] cs_n;
    logic [1:0] sck;
    logic [1:0] si;
    logic [1:0] hold_n;
    logic [1:0] wp_n;
  } snvwp_sync_s;

  typedef struct packed {
    logic lock;
    logic [2:0] spare;
    logic [1:0] bp;
    logic latch;
  } snvwp_status_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`SNVWP_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } snvwp_mem_req_s;

  typedef struct packed {
    snvwp_sync_s sync;
    logic sck_prev;
    snvwp_phase_e phase;
    logic [4:0] bit_cnt;
    logic [23:0] shift_in;
    logic is_write;
    logic wr_recognised;
    snvwp_status_s status;
    logic load_pend;
    logic load_status;
    logic [7:0] out_shift;
    logic so;
    logic so_oe;
    logic hold;
    snvwp_mem_req_s mem;
  } snvwp_state_s;

endpackage : snvwp_pkg

`default_nettype wire

/* File: verif/snvwp_core_checker.sv */
/*
  Port checker of the write-protect and hold core, bound to snvwp_core.
  Assumes the pin synchronisers and registers of the hand-over timing.
*/
`default_nettype none
`include "snvwp_regs.svh"

module snvwp_core_checker (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Watched ports.
  input wire logic spi_cs_n_i,
  input wire logic spi_so_oe_o,
  input wire snvwp_pkg::snvwp_mem_req_s mem_req_o,
  input wire snvwp_pkg::snvwp_status_s status_o,
  input wire logic hold_active_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_hold_no_output: assert property (
    hold_active_o && $past(hold_active_o) |-> !spi_so_oe_o)
    else $error("output enabled during hold");
  a_hold_frozen: assert property (
    hold_active_o && $past(hold_active_o) |->
      $stable(status_o) && !mem_req_o.wr && !mem_req_o.rd)
    else $error("state moved during hold");
  a_hold_needs_sel: assert property (
    spi_cs_n_i [*5] |-> !hold_active_o)
    else $error("hold active while deselected");
  a_oe_needs_sel: assert property (
    spi_cs_n_i [*5] |-> !spi_so_oe_o)
    else $error("output enabled while deselected");
  a_wr_one_cycle: assert property (
    mem_req_o.wr |=> !mem_req_o.wr)
    else $error("write strobe longer than one cycle");
  a_wr_needs_latch: assert property (
    mem_req_o.wr |-> status_o.latch)
    else $error("write with latch clear");
  a_wr_outside_range: assert property (
    mem_req_o.wr |-> (status_o.bp == 2'h0) ||
      (status_o.bp == 2'h1 && mem_req_o.addr < `SNVWP_QUARTER_BASE) ||
      (status_o.bp == 2'h2 && mem_req_o.addr < `SNVWP_HALF_BASE))
    else $error("write inside protected range");
  a_rd_then_drive: assert property (
    mem_req_o.rd |-> ##[1:8] spi_so_oe_o)
    else $error("read data not driven");

  c_write: cover property (mem_req_o.wr);
  c_read: cover property (mem_req_o.rd);
  c_hold: cover property (hold_active_o && !spi_so_oe_o);
endmodule : snvwp_core_checker

bind snvwp_core snvwp_core_checker u_checker (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .spi_cs_n_i(spi_cs_n_i),
  .spi_so_oe_o(spi_so_oe_o),
  .mem_req_o(mem_req_o),
  .status_o(status_o),
  .hold_active_o(hold_active_o)
);

`default_nettype wire

/* File: verif/snvwp_host_model.sv */
/*
  Behavioural SPI host in mode 0: frames, bits and hold pauses.
  Assumes it shares core_clk_i with the device; each sck phase is 6 cycles, 4 while hold is low.
*/
`default_nettype none

module snvwp_host_model (
  // Clock.
  input wire logic core_clk_i,
  // Pins toward the device.
  output logic spi_cs_n_o,
  output logic spi_sck_o,
  output logic spi_si_o,
  output logic spi_hold_n_o,
  // Pins from the device.
  input wire logic spi_so_i,
  input wire logic spi_so_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_cs_n_o = 1'b1;
    spi_sck_o = 1'b0;
    spi_si_o = 1'b0;
    spi_hold_n_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick

  // A released output reads as floating so a missing drive never matches.
  task automatic xbit(input logic b, output logic r);
    spi_si_o <= b;
    tick(5);
    @(negedge core_clk_i);
    r = spi_so_oe_i ? spi_so_i : 1'bz;
    @(posedge core_clk_i);
    spi_sck_o <= 1'b1;
    tick(6);
    spi_sck_o <= 1'b0;
  endtask : xbit

  task automatic hold_on(input int n);
    tick(2);
    spi_hold_n_o <= 1'b0;
    tick(8);
    repeat (n) begin
      spi_sck_o <= 1'b1;
      spi_si_o <= ~spi_si_o;
      tick(4);
      spi_sck_o <= 1'b0;
      tick(4);
    end
  endtask : hold_on

  task automatic hold_off(input logic abort);
    if (abort) begin
      spi_cs_n_o <= 1'b1;
      tick(8);
    end
    spi_hold_n_o <= 1'b1;
    tick(8);
  endtask : hold_off

  task automatic xbyte(input logic [7:0] tx, input logic hmid, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      if (hmid && i == 3) begin
        hold_on(3);
        hold_off(1'b0);
      end
      xbit(tx[i], r);
      rx[i] = r;
    end
  endtask : xbyte

  task automatic sel();
    spi_cs_n_o <= 1'b0;
    tick(4);
  endtask : sel

  task automatic desel();
    tick(4);
    spi_cs_n_o <= 1'b1;
    tick(6);
  endtask : desel
endmodule : snvwp_host_model

`default_nettype wire

/* File: verif/snvwp_core_tb.sv */
/*
  Self-checking bench of snvwp_core with an SPI host model and a memory stub.
  Assumes the memory answers combinationally with addr[7:0] xor 5Ah.
*/
`default_nettype none
`include "snvwp_regs.svh"

module snvwp_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [1:0] bp;
    logic latch;
    logic [16:0] addr;
    logic ok;
  } snvwp_tb_row_s;

  localparam snvwp_tb_row_s ROWS [7] = '{
    '{2'h0, 1'b1, 17'h1FFFF, 1'b1}, '{2'h1, 1'b1, 17'h17FFF, 1'b1},
    '{2'h1, 1'b1, 17'h18000, 1'b0}, '{2'h2, 1'b1, 17'h0FFFF, 1'b1},
    '{2'h2, 1'b1, 17'h10000, 1'b0}, '{2'h3, 1'b1, 17'h00000, 1'b0},
    '{2'h0, 1'b0, 17'h00000, 1'b0}};

  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wp_n_i = 1'b1;
  logic cs_n, sck, si, hold_n, so, so_oe, hold_active;
  snvwp_pkg::snvwp_mem_req_s mem_req;
  snvwp_pkg::snvwp_status_s status;
  logic [7:0] rd_data, rv, v;
  logic r;
  int fail_count = 0, n_checks = 0, wr_count = 0, cycles = 0, n0;
  logic [16:0] wr_addr;
  logic [7:0] wr_data;

  assign rd_data = mem_req.addr[7:0] ^ 8'h5A;

  snvwp_core dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .spi_cs_n_i(cs_n),
    .spi_sck_i(sck), .spi_si_i(si), .spi_hold_n_i(hold_n), .wp_n_i(wp_n_i),
    .spi_so_o(so), .spi_so_oe_o(so_oe), .mem_req_o(mem_req), .mem_rd_data_i(rd_data),
    .status_o(status), .hold_active_o(hold_active));
  snvwp_host_model host (.core_clk_i(core_clk_i), .spi_cs_n_o(cs_n), .spi_sck_o(sck),
    .spi_si_o(si), .spi_hold_n_o(hold_n), .spi_so_i(so), .spi_so_oe_i(so_oe));

  initial begin
    forever #2 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (mem_req.wr === 1'b1) begin
      wr_count++;
      wr_addr = mem_req.addr;
      wr_data = mem_req.wdata;
    end
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic check_val(input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask : check_val

  task automatic cmd1(input logic [7:0] op);
    host.sel();
    host.xbyte(op, 1'b0, rv);
    host.desel();
  endtask : cmd1

  task automatic stwr(input logic [7:0] d);
    host.sel();
    host.xbyte(`SNVWP_OP_STATUS_WRITE, 1'b0, rv);
    host.xbyte(d, 1'b0, rv);
    host.desel();
  endtask : stwr

  // The ignored upper address bits carry a nonzero pattern on purpose.
  task automatic memop(input logic [7:0] op, input logic [16:0] a, input logic [7:0] d,
      input logic hmid);
    host.sel();
    host.xbyte(op, 1'b0, rv);
    host.xbyte({7'h2A, a[16]}, 1'b0, rv);
    host.xbyte(a[15:8], 1'b0, rv);
    host.xbyte(a[7:0], 1'b0, rv);
    host.xbyte(d, hmid, rv);
    host.desel();
  endtask : memop

  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    host.tick(4);
    check_val(7'h00, status);
    foreach (ROWS[i]) begin
      cmd1(`SNVWP_OP_LATCH_SET);
      stwr({4'h0, ROWS[i].bp, 2'h0});
      check_val(ROWS[i].bp, status.bp);
      if (ROWS[i].latch) cmd1(`SNVWP_OP_LATCH_SET);
      n0 = wr_count;
      memop(`SNVWP_OP_MEM_WRITE, ROWS[i].addr, 8'hA0 + i[7:0], 1'b0);
      check_val(n0 + ROWS[i].ok, wr_count);
      if (ROWS[i].ok) check_val({ROWS[i].addr, 8'hA0 + i[7:0]}, {wr_addr, wr_data});
      check_val(1'b0, status.latch);
    end
    cmd1(`SNVWP_OP_LATCH_SET);
    stwr(8'h84);
    wp_n_i <= 1'b0;
    cmd1(`SNVWP_OP_LATCH_SET);
    stwr(8'h00);
    check_val(7'h42, status);
    cmd1(`SNVWP_OP_LATCH_SET);
    memop(`SNVWP_OP_MEM_WRITE, 17'h00010, 8'h3C, 1'b0);
    check_val(17'h00010, wr_addr);
    wp_n_i <= 1'b1;
    cmd1(`SNVWP_OP_LATCH_SET);
    stwr(8'h00);
    check_val(7'h00, status);
    stwr(8'h0C);
    check_val(7'h00, status);
    cmd1(`SNVWP_OP_LATCH_SET);
    host.sel();
    host.xbyte(`SNVWP_OP_STATUS_READ, 1'b0, rv);
    host.xbyte(8'h00, 1'b1, v);
    host.desel();
    check_val(8'h02, v);
    memop(`SNVWP_OP_MEM_READ, 17'h1ABCD, 8'h00, 1'b1);
    check_val(8'hCD ^ 8'h5A, rv);
    host.sel();
    for (int i = 0; i < 4; i++) host.xbit(1'b0, r);
    host.hold_on(2);
    check_val(2'b10, {hold_active, so_oe});
    host.hold_off(1'b1);
    check_val(1'b1, status.latch);
    n0 = wr_count;
    host.sel();
    host.xbyte(`SNVWP_OP_MEM_WRITE, 1'b0, rv);
    for (int i = 0; i < 3; i++) host.xbyte(8'h00, 1'b0, rv);
    for (int i = 0; i < 5; i++) host.xbit(1'b1, r);
    host.hold_on(2);
    host.hold_off(1'b1);
    check_val(n0, wr_count);
    check_val(1'b0, status.latch);
    cmd1(`SNVWP_OP_LATCH_SET);
    host.sel();
    host.xbyte(8'hFF, 1'b0, rv);
    host.xbyte(`SNVWP_OP_LATCH_CLEAR, 1'b0, rv);
    host.desel();
    check_val(1'b1, status.latch);
    cmd1(`SNVWP_OP_LATCH_CLEAR);
    check_val(1'b0, status.latch);
    cmd1(`SNVWP_OP_LATCH_SET);
    check_val(1'b1, status.latch);
    reset_n_i <= 1'b0;
    host.tick(5);
    reset_n_i <= 1'b1;
    host.tick(4);
    check_val(7'h00, status);
    cmd1(`SNVWP_OP_LATCH_SET);
    check_val(1'b1, status.latch);
    conclude();
  end
endmodule : snvwp_core_tb

`default_nettype wire
